// File: logic/spa_assembler.sv
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
module spa_assembler #(
  parameter int SEC_CYCLES = spa_pkg::SEC_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pull_en,
  output logic pull_up,
  output spa_pkg::spa_adc_cfg_t [3:0] adc_cfg,
  input wire logic [3:0][11:0] adc_raw,
  input wire logic [13:0] sens_temp,
  input wire logic [11:0] sens_hum,
  input wire logic [7:0] nbr_total,
  output logic [7:0] nbr_sel,
  input wire spa_pkg::spa_nbr_t nbr_entry,
  output spa_pkg::spa_byte_t pkt,
  output logic pkt_valid,
  output logic [31:0] target_station_id,
  input wire logic pkt_ready
);

  // merge write data into a register under byte enables
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // interval in seconds, clamped to the legal span
  function automatic logic [16:0] ival_secs(input logic [31:0] cfg);
    logic [27:0] s;
    logic [1:0] u;
    u = cfg[spa_pkg::IVAL_UNIT_LSB +: 2];
    if (u == spa_pkg::UNIT_SEC) begin
      s = {12'h000, cfg[15:0]};
    end else if (u == spa_pkg::UNIT_MIN) begin
      s = 28'(cfg[15:0]) * 28'(spa_pkg::SEC_PER_MIN);
    end else begin
      s = 28'(cfg[15:0]) * 28'(spa_pkg::SEC_PER_HOUR);
    end
    if (s < 28'(spa_pkg::MIN_IVAL_S)) begin
      s = 28'(spa_pkg::MIN_IVAL_S);
    end else if (s > 28'(spa_pkg::MAX_IVAL_S)) begin
      s = 28'(spa_pkg::MAX_IVAL_S);
    end
    return s[16:0];
  endfunction

  // left-justify a right-justified converter result
  function automatic logic [15:0] adc_align(input logic [11:0] raw, input spa_pkg::spa_res_t res);
    unique case (res)
      spa_pkg::RES_7: adc_align = {raw[6:0], 9'h000};
      spa_pkg::RES_9: adc_align = {raw[8:0], 7'h00};
      spa_pkg::RES_10: adc_align = {raw[9:0], 6'h00};
      spa_pkg::RES_12: adc_align = {raw, 4'h0};
    endcase
  endfunction

  // software-visible configuration
  logic wait_r;
  logic [31:0] rdata_r;
  spa_pkg::spa_app_t app_r;
  logic [7:0] tag_r;
  logic [31:0] dest_r;
  logic [31:0] ival_r;
  logic [15:0] pmode_r;
  logic [31:0] pcfg_r;
  logic [7:0] dout_r;
  logic [31:0] adc_r;
  // sampling and assembly state
  logic [7:0] prev_r;
  logic [7:0] flags_r;
  logic [15:0] cnt_r;
  logic [$clog2(SEC_CYCLES)-1:0] sec_cnt_r;
  logic sec_tick_r;
  logic [16:0] ival_cnt_r;
  logic trig_r;
  spa_pkg::spa_state_t state_r;
  logic [7:0] buf_r [spa_pkg::BUF_BYTES];
  logic [4:0] len_r;
  logic [4:0] pos_r;
  logic [2:0] fetch_r;
  logic [7:0] base_r;

  logic req;
  logic [7:0] din_lines;
  logic [7:0] dout_lines;
  logic [7:0] fall;
  logic [2:0] cnt_line;
  logic cnt_inc;
  logic snap;
  logic [2:0] nbr_n;
  logic [8:0] nbr_idx;
  logic [3:0][15:0] adc_word;

  assign req = avs_read | avs_write;
  assign cnt_line = pcfg_r[spa_pkg::PCFG_CNT_LSB +: 3];
  assign nbr_n = (nbr_total > 8'(spa_pkg::NBR_GROUP)) ? spa_pkg::NBR_GROUP : nbr_total[2:0];
  assign nbr_idx = 9'(base_r) + 9'(fetch_r);

  // per-line mode decode
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      din_lines[i] = pmode_r[2*i +: 2] == spa_pkg::PM_DIN;
      dout_lines[i] = pmode_r[2*i +: 2] == spa_pkg::PM_DOUT;
    end
  end

  // converter results left-justified per channel resolution
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      adc_word[c] = adc_align(adc_raw[c], spa_pkg::spa_res_t'(adc_r[8*c +: 2]));
    end
  end

  // falling edges on digital inputs; package snapshot only for the pin app
  assign fall = din_lines & prev_r & ~pin_in;
  assign cnt_inc = pcfg_r[spa_pkg::PCFG_CNT_EN] && fall[cnt_line];
  assign snap = trig_r && state_r == spa_pkg::ST_IDLE && app_r == spa_pkg::APP_PINS;

  // avalon slave: answer one cycle after the request, waitrequest low for one cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= !(req && wait_r);
      if (avs_read && wait_r) begin
        unique case (avs_address)
          spa_pkg::OFS_CTRL: rdata_r <= {30'h0, app_r};
          spa_pkg::OFS_TAG: rdata_r <= {24'h0, tag_r};
          spa_pkg::OFS_DEST: rdata_r <= dest_r;
          spa_pkg::OFS_IVAL: rdata_r <= ival_r;
          spa_pkg::OFS_PMODE: rdata_r <= {16'h0, pmode_r};
          spa_pkg::OFS_PCFG: rdata_r <= pcfg_r;
          spa_pkg::OFS_DOUT: rdata_r <= {24'h0, dout_r};
          spa_pkg::OFS_ADC: rdata_r <= adc_r;
          spa_pkg::OFS_STAT: rdata_r <= {15'h0, state_r != spa_pkg::ST_IDLE, flags_r, pin_in};
          spa_pkg::OFS_COUNT: rdata_r <= {16'h0, cnt_r};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // register writes take effect at the edge where waitrequest is low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      app_r <= spa_pkg::APP_UART;
      tag_r <= 8'h00;
      dest_r <= 32'h0000_0000;
      ival_r <= spa_pkg::RST_IVAL;
      pmode_r <= 16'h0000; // all digital
      pcfg_r <= spa_pkg::RST_PCFG;
      dout_r <= 8'h00;
      adc_r <= 32'h0000_0000;
    end else if (avs_write && !wait_r) begin
      unique case (avs_address)
        spa_pkg::OFS_CTRL: app_r <= avs_byteenable[0] ? spa_pkg::spa_app_t'(avs_writedata[1:0])
                                                      : app_r;
        spa_pkg::OFS_TAG: tag_r <= avs_byteenable[0] ? avs_writedata[7:0] : tag_r;
        spa_pkg::OFS_DEST: dest_r <= wmerge(dest_r, avs_writedata, avs_byteenable);
        spa_pkg::OFS_IVAL: ival_r <= wmerge(ival_r, avs_writedata, avs_byteenable);
        spa_pkg::OFS_PMODE: pmode_r <= 16'(wmerge(32'(pmode_r), avs_writedata,
                                                   avs_byteenable));
        spa_pkg::OFS_PCFG: pcfg_r <= wmerge(pcfg_r, avs_writedata, avs_byteenable);
        spa_pkg::OFS_DOUT: dout_r <= avs_byteenable[0] ? avs_writedata[7:0] : dout_r;
        spa_pkg::OFS_ADC: adc_r <= wmerge(adc_r, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
  end

  // pad control and converter setup, all registered
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      pull_en <= 8'h00;
      pull_up <= 1'b0;
      adc_cfg <= '0;
    end else begin
      pin_out <= dout_r;
      pin_oe <= dout_lines;
      pull_en <= din_lines & ~pcfg_r[spa_pkg::PCFG_TRI_LSB +: 8];
      pull_up <= pcfg_r[spa_pkg::PCFG_PULLUP];
      adc_cfg <= adc_r;
    end
  end

  // edge flags and counter; a new edge wins over the restart
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_r <= 8'h00;
      flags_r <= 8'h00;
      cnt_r <= 16'h0000;
    end else begin
      prev_r <= pin_in;
      flags_r <= (snap ? 8'h00 : flags_r) | fall;
      if (snap) begin
        cnt_r <= cnt_inc ? 16'h0001 : 16'h0000;
      end else if (cnt_inc && cnt_r != spa_pkg::CNT_MAX) begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  // one-second tick and package interval
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sec_cnt_r <= '0;
      sec_tick_r <= 1'b0;
      ival_cnt_r <= 17'h00000;
      trig_r <= 1'b0;
    end else begin
      sec_tick_r <= sec_cnt_r == ($clog2(SEC_CYCLES))'(SEC_CYCLES - 1);
      sec_cnt_r <= (sec_cnt_r == ($clog2(SEC_CYCLES))'(SEC_CYCLES - 1)) ? '0 : sec_cnt_r + 1'b1;
      trig_r <= 1'b0;
      if (sec_tick_r) begin
        if (ival_cnt_r >= ival_secs(ival_r) - 17'h00001) begin
          ival_cnt_r <= 17'h00000;
          trig_r <= app_r != spa_pkg::APP_UART;
        end else begin
          ival_cnt_r <= ival_cnt_r + 17'h00001;
        end
      end
    end
  end

  // package assembly and byte stream
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= spa_pkg::ST_IDLE;
      for (int i = 0; i < spa_pkg::BUF_BYTES; i++) begin
        buf_r[i] <= 8'h00;
      end
      len_r <= 5'd0;
      pos_r <= 5'd0;
      fetch_r <= 3'd0;
      base_r <= 8'h00;
      nbr_sel <= 8'h00;
      pkt <= '0;
      pkt_valid <= 1'b0;
      target_station_id <= 32'h0000_0000;
    end else begin
      unique case (state_r)
        spa_pkg::ST_IDLE: begin
          pos_r <= 5'd0;
          fetch_r <= 3'd0;
          if (trig_r) begin
            buf_r[0] <= tag_r;
            target_station_id <= dest_r;
            if (app_r == spa_pkg::APP_PINS) begin
              buf_r[1] <= flags_r;
              buf_r[2] <= pin_in & pcfg_r[7:0];
              buf_r[3] <= cnt_r[15:8];
              buf_r[4] <= cnt_r[7:0];
              for (int c = 0; c < 4; c++) begin
                buf_r[5+2*c] <= adc_word[c][15:8];
                buf_r[6+2*c] <= adc_word[c][7:0];
              end
              len_r <= spa_pkg::LEN_PINS;
              state_r <= spa_pkg::ST_SEND;
            end else if (app_r == spa_pkg::APP_SENSOR) begin
              buf_r[1] <= sens_temp[13:6];
              buf_r[2] <= {sens_temp[5:0], 2'b00};
              buf_r[3] <= sens_hum[11:4];
              buf_r[4] <= {sens_hum[3:0], 4'h0};
              len_r <= spa_pkg::LEN_SENSOR;
              state_r <= spa_pkg::ST_SEND;
            end else if (app_r == spa_pkg::APP_NBR) begin
              if (base_r >= nbr_total) begin
                base_r <= 8'h00;
              end
              state_r <= spa_pkg::ST_FETCH;
            end
          end
        end
        spa_pkg::ST_FETCH: begin
          // select entry f, capture entry f-1 that was selected last cycle
          nbr_sel <= (nbr_idx >= 9'(nbr_total)) ? 8'(nbr_idx - 9'(nbr_total)) : nbr_idx[7:0];
          if (fetch_r != 3'd0) begin
            buf_r[3*fetch_r - 2] <= nbr_entry.id[15:8];
            buf_r[3*fetch_r - 1] <= nbr_entry.id[7:0];
            buf_r[3*fetch_r] <= 8'(-nbr_entry.dbm);
          end
          if (fetch_r == nbr_n) begin
            len_r <= 5'd1 + 5'(3 * nbr_n);
            base_r <= ((9'(base_r) + 9'(nbr_n)) >= 9'(nbr_total)) ?
                      8'(9'(base_r) + 9'(nbr_n) - 9'(nbr_total)) : base_r + 8'(nbr_n);
            state_r <= spa_pkg::ST_SEND;
          end else begin
            fetch_r <= fetch_r + 3'd1;
          end
        end
        spa_pkg::ST_SEND: begin
          if (!pkt_valid || pkt_ready) begin
            if (pos_r < len_r) begin
              pkt.data <= buf_r[pos_r[3:0]];
              pkt.last <= pos_r == len_r - 5'd1;
              pkt_valid <= 1'b1;
              pos_r <= pos_r + 5'd1;
            end else begin
              pkt_valid <= 1'b0;
              pkt.last <= 1'b0;
              state_r <= spa_pkg::ST_IDLE;
            end
          end
        end
        default: state_r <= spa_pkg::ST_IDLE;
      endcase
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;

  // checks
  a_wait_one_cycle: assert property (@(posedge clk) disable iff (!nrst)
    !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
  a_tag_lead_byte: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == spa_pkg::ST_IDLE && trig_r) |=> buf_r[0] == $past(tag_r))
    else $error("tag byte not placed first");
  a_dest_latch: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == spa_pkg::ST_IDLE && trig_r) |=> target_station_id == $past(dest_r))
    else $error("destination not latched");
  a_uart_silent: assert property (@(posedge clk) disable iff (!nrst)
    (app_r == spa_pkg::APP_UART && $past(app_r) == spa_pkg::APP_UART) |-> !trig_r)
    else $error("package triggered in host mode");
  a_flags_restart: assert property (@(posedge clk) disable iff (!nrst)
    (snap && fall == 8'h00 && !cnt_inc) |=> (flags_r == 8'h00 && cnt_r == 16'h0000))
    else $error("flags or counter not restarted");
  a_flag_sticky: assert property (@(posedge clk) disable iff (!nrst)
    fall != 8'h00 |=> (flags_r & $past(fall)) == $past(fall)) else $error("edge flag lost");
  a_cnt_saturate: assert property (@(posedge clk) disable iff (!nrst)
    (cnt_r == spa_pkg::CNT_MAX && !snap) |=> cnt_r == spa_pkg::CNT_MAX)
    else $error("counter wrapped");
  a_pull_tristate: assert property (@(posedge clk) disable iff (!nrst)
    ##1 (pull_en & $past(pcfg_r[spa_pkg::PCFG_TRI_LSB +: 8])) == 8'h00)
    else $error("tri-stated line pulled");
  a_pkt_hold: assert property (@(posedge clk) disable iff (!nrst)
    (pkt_valid && !pkt_ready) |=> (pkt_valid && $stable(pkt))) else $error("byte dropped");
  a_last_len: assert property (@(posedge clk) disable iff (!nrst)
    (pkt_valid && pkt.last) |-> (pos_r == len_r && len_r <= 5'd16)) else $error("bad length");

endmodule

// File: logic/spa_pkg.sv
package spa_pkg;
  // timing
  localparam int CLK_NS = 4;
  localparam longint SEC_NS = 64'd1000000000;
  localparam int SEC_CYCLES = int'(SEC_NS / CLK_NS);
  localparam logic [16:0] MIN_IVAL_S = 17'h0000a;
  localparam logic [16:0] MAX_IVAL_S = 17'h15180;
  localparam logic [15:0] SEC_PER_MIN = 16'h003c;
  localparam logic [15:0] SEC_PER_HOUR = 16'h0e10;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TAG = 8'h04;
  localparam logic [7:0] OFS_DEST = 8'h08;
  localparam logic [7:0] OFS_IVAL = 8'h0c;
  localparam logic [7:0] OFS_PMODE = 8'h10;
  localparam logic [7:0] OFS_PCFG = 8'h14;
  localparam logic [7:0] OFS_DOUT = 8'h18;
  localparam logic [7:0] OFS_ADC = 8'h1c;
  localparam logic [7:0] OFS_STAT = 8'h20;
  localparam logic [7:0] OFS_COUNT = 8'h24;
  // field positions
  localparam int IVAL_UNIT_LSB = 16;
  localparam int PCFG_TRI_LSB = 8;
  localparam int PCFG_PULLUP = 16;
  localparam int PCFG_CNT_EN = 17;
  localparam int PCFG_CNT_LSB = 18;
  localparam int STAT_FLAG_LSB = 8;
  localparam int STAT_BUSY = 16;
  // reset values and counter saturation limit
  localparam logic [31:0] RST_IVAL = 32'h0001_0001;
  localparam logic [31:0] RST_PCFG = 32'h0001_0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  // packet shape
  localparam int BUF_BYTES = 16;
  localparam logic [4:0] LEN_PINS = 5'd13;
  localparam logic [4:0] LEN_SENSOR = 5'd5;
  localparam logic [2:0] NBR_GROUP = 3'd5;
  typedef enum logic [1:0] {
    APP_UART = 2'b00, APP_PINS = 2'b01, APP_SENSOR = 2'b10, APP_NBR = 2'b11
  } spa_app_t;
  typedef enum logic [1:0] {
    PM_DIN = 2'b00, PM_DOUT = 2'b01, PM_AIN = 2'b10, PM_RSVD = 2'b11
  } spa_pmode_t;
  localparam logic [1:0] UNIT_SEC = 2'b00;
  localparam logic [1:0] UNIT_MIN = 2'b01;
  typedef enum logic [1:0] {
    RES_7 = 2'b00, RES_9 = 2'b01, RES_10 = 2'b10, RES_12 = 2'b11
  } spa_res_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_FETCH = 2'b01, ST_SEND = 2'b10} spa_state_t;
  // converter channel setup: src 0-7 line, 8-11 line pair, 12 temp, 13 supply/3
  typedef struct packed {
    logic [3:0] src;
    logic [1:0] refsel;
    spa_res_t res;
  } spa_adc_cfg_t;
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } spa_byte_t;
  typedef struct packed {
    logic [15:0] id;
    logic signed [7:0] dbm;
  } spa_nbr_t;
endpackage

// File: verification/spa_sink.sv
`timescale 1ns/1ns
// remote node model: takes the byte stream, may stall
module spa_sink (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slow,
  input wire spa_pkg::spa_byte_t pkt,
  input wire logic pkt_valid,
  output logic pkt_ready,
  output logic [15:0] temp_clean,
  output logic [15:0] hum_clean,
  output logic [4:0] rx_len
);
  logic [1:0] ph_r;
  logic [4:0] idx_r;
  logic [7:0] b1_r, b2_r, b3_r;
  // when slow, ready only one cycle in four
  assign pkt_ready = !slow || (ph_r == 2'h0);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph_r <= 2'h0;
    end else begin
      ph_r <= ph_r + 2'h1;
    end
  end
  // gather a frame; undefined low bits cleared on receipt
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idx_r <= 5'h00;
      rx_len <= 5'h00;
      temp_clean <= 16'h0000;
      hum_clean <= 16'h0000;
    end else if (pkt_valid && pkt_ready) begin
      idx_r <= pkt.last ? 5'h00 : idx_r + 5'h01;
      if (idx_r == 5'h01) b1_r <= pkt.data;
      if (idx_r == 5'h02) b2_r <= pkt.data;
      if (idx_r == 5'h03) b3_r <= pkt.data;
      if (pkt.last) begin
        rx_len <= idx_r + 5'h01;
        temp_clean <= {b1_r, b2_r} & 16'hfffc;
        hum_clean <= {b3_r, pkt.data} & 16'hfff0;
      end
    end
  end
endmodule

// File: verification/spa_assembler_tb_top.sv
`timescale 1ns/1ns
module spa_assembler_tb_top;
  typedef struct packed {logic last; logic [7:0] data; logic [7:0] mask;} spa_sb_t;
  logic clk, nrst, avs_read, avs_write, avs_waitrequest, pull_up, pkt_valid, pkt_ready;
  logic [7:0] avs_address, pin_in, pin_out, pin_oe, pull_en, nbr_total, nbr_sel, tag;
  logic [31:0] avs_writedata, avs_readdata, target_station_id, rd, seed, dest;
  logic [3:0] avs_byteenable;
  spa_pkg::spa_adc_cfg_t [3:0] adc_cfg;
  logic [3:0][11:0] adc_raw;
  logic [13:0] sens_temp;
  logic [11:0] sens_hum;
  spa_pkg::spa_nbr_t nbr_entry;
  spa_pkg::spa_byte_t pkt;
  logic slow, watch, pv_d;
  logic [15:0] temp_clean, hum_clean;
  logic [4:0] rx_len;
  int bad_count, checked, cyc, last_rise, last_gap;
  spa_sb_t exp_q[$];
  spa_sb_t sb_e;

  spa_assembler #(.SEC_CYCLES(20)) u_spa_assembler (.clk(clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en), .pull_up(pull_up),
    .adc_cfg(adc_cfg), .adc_raw(adc_raw), .sens_temp(sens_temp), .sens_hum(sens_hum),
    .nbr_total(nbr_total), .nbr_sel(nbr_sel), .nbr_entry(nbr_entry), .pkt(pkt),
    .pkt_valid(pkt_valid), .target_station_id(target_station_id), .pkt_ready(pkt_ready));
  spa_sink u_spa_sink (.clk(clk), .nrst(nrst), .slow(slow), .pkt(pkt),
    .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .temp_clean(temp_clean),
    .hum_clean(hum_clean), .rx_len(rx_len));

  // neighbour table: id a0xx, level -(40+index) dBm
  assign nbr_entry = {8'ha0, nbr_sel, 8'h00 - (8'h28 + nbr_sel)};

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("counts: %0d checked, %0d mismatched", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one bus cycle; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (avs_waitrequest !== 1'b0) bad_count++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic push(input logic [7:0] d, input logic [7:0] m, input logic l);
    exp_q.push_back({l, d, m});
  endtask

  task automatic wait_last();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(pkt_valid === 1'b1 && pkt_ready === 1'b1 && pkt.last === 1'b1) && n < 3000);
    if (n >= 3000) bad_count++;
  endtask

  task automatic wait_rise();
    int n, r;
    n = 0;
    r = last_rise;
    while (last_rise == r && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (last_rise == r) bad_count++;
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check("queue left", exp_q.size(), 32'h0);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // compare each accepted byte with the oldest note while watch is set
  always @(posedge clk) begin
    if (watch && pkt_valid === 1'b1 && pkt_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("extra byte", 32'h1, 32'h0);
      end else begin
        sb_e = exp_q.pop_front();
        check("pkt data", pkt.data & sb_e.mask, sb_e.data & sb_e.mask);
        check("pkt last", pkt.last, sb_e.last);
      end
    end
  end

  // package spacing and run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pv_d <= pkt_valid;
    if (pkt_valid === 1'b1 && pv_d !== 1'b1) begin
      last_gap <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    logic [31:0] ivs[3];
    int gaps[3];
    int res_bits[4];
    logic [15:0] aw, am;
    ivs = '{32'h0000_000a, 32'h0000_0005, 32'h0001_0001};
    gaps = '{200, 200, 1200};
    res_bits = '{7, 9, 10, 12};
    nrst = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    pin_in = 8'hbf;
    slow = 1'b1;
    watch = 1'b1;
    nbr_total = 8'h0a;
    seed = 32'h0001_0c26;
    for (int c = 0; c < 4; c++) begin
      seed = lfsr_next(seed);
      adc_raw[c] = seed[11:0];
    end
    seed = lfsr_next(seed);
    sens_temp = seed[13:0];
    sens_hum = seed[27:16];
    seed = lfsr_next(seed);
    dest = seed;
    tag = seed[15:8];
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    check("pin_oe", pin_oe, 32'h0);
    check("pull_en", pull_en, 32'hff);
    bus(1'b0, spa_pkg::OFS_PCFG, 32'h0);
    check("pcfg", rd, spa_pkg::RST_PCFG);
    bus(1'b0, spa_pkg::OFS_IVAL, 32'h0);
    check("ival", rd, spa_pkg::RST_IVAL);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("test reset values done");
    // neighbours in two groups of five
    bus(1'b1, spa_pkg::OFS_IVAL, 32'h0000_000a);
    bus(1'b1, spa_pkg::OFS_TAG, {24'h0, tag});
    bus(1'b1, spa_pkg::OFS_DEST, dest);
    for (int g = 0; g < 2; g++) begin
      push(tag, 8'hff, 1'b0);
      for (int k = 0; k < 5; k++) begin
        push(8'ha0, 8'hff, 1'b0);
        push(8'(g * 5 + k), 8'hff, 1'b0);
        push(8'h28 + 8'(g * 5 + k), 8'hff, k == 4);
      end
    end
    bus(1'b1, spa_pkg::OFS_CTRL, 32'h3);
    drain();
    bus(1'b1, spa_pkg::OFS_CTRL, 32'h0);
    check("dest", target_station_id, dest);
    $display("test neighbours done");
    // line setup and converter selections
    bus(1'b1, spa_pkg::OFS_PMODE, 32'h9);
    bus(1'b1, spa_pkg::OFS_PCFG, 32'h0003_80ff);
    bus(1'b1, spa_pkg::OFS_DOUT, 32'ha5);
    bus(1'b1, spa_pkg::OFS_ADC, 32'hdfca_8520);
    repeat (2) @(posedge clk);
    check("adc cfg", adc_cfg, 32'hdfca_8520);
    check("pin_oe", pin_oe, 32'h01);
    check("pull_en", pull_en, 32'h7c);
    check("pull_up", pull_up, 32'h1);
    check("pin_out", pin_out, 32'ha5);
    bus(1'b1, spa_pkg::OFS_PCFG, 32'h0002_00ff);
    repeat (2) @(posedge clk);
    check("pull down", {pull_up, pull_en}, 32'h0fc);
    bus(1'b1, spa_pkg::OFS_PMODE, 32'h0);
    bus(1'b1, spa_pkg::OFS_PCFG, 32'h0003_00ff);
    bus(1'b1, spa_pkg::OFS_ADC, 32'hd3c2_8120);
    $display("test line setup done");
    // pin sampler: edges after one package, then a quiet one
    watch <= 1'b0;
    slow <= 1'b0;
    bus(1'b1, spa_pkg::OFS_CTRL, 32'h1);
    wait_rise();
    wait_last();
    watch <= 1'b1;
    repeat (5) begin
      pin_in <= pin_in & 8'hfe;
      repeat (2) @(posedge clk);
      pin_in <= pin_in | 8'h01;
      repeat (2) @(posedge clk);
    end
    pin_in <= 8'hf7;
    for (int p = 0; p < 2; p++) begin
      push(tag, 8'hff, 1'b0);
      push(p == 0 ? 8'h09 : 8'h00, 8'hff, 1'b0);
      push(8'hf7, 8'hff, 1'b0);
      push(8'h00, 8'hff, 1'b0);
      push(p == 0 ? 8'h05 : 8'h00, 8'hff, 1'b0);
      for (int c = 0; c < 4; c++) begin
        aw = {adc_raw[c], 4'h0} << (12 - res_bits[c]);
        am = 16'hffff << (16 - res_bits[c]);
        push(aw[15:8], am[15:8], 1'b0);
        push(aw[7:0], am[7:0], c == 3);
      end
    end
    drain();
    $display("test pin sampler done");
    // sensor package, remote side stalling
    watch <= 1'b0;
    slow <= 1'b1;
    bus(1'b1, spa_pkg::OFS_CTRL, 32'h2);
    wait_rise();
    wait_last();
    watch <= 1'b1;
    push(tag, 8'hff, 1'b0);
    seed = lfsr_next(seed);
    sens_temp <= seed[13:0];
    sens_hum <= seed[27:16];
    push(seed[13:6], 8'hff, 1'b0);
    push({seed[5:0], 2'b00}, 8'hfc, 1'b0);
    push(seed[27:20], 8'hff, 1'b0);
    push({seed[19:16], 4'h0}, 8'hf0, 1'b1);
    drain();
    @(posedge clk);
    check("temp", temp_clean, {seed[13:0], 2'b00});
    check("hum", hum_clean, {seed[27:16], 4'h0});
    check("len", rx_len, 32'h5);
    $display("test sensor done");
    // spacing of packages per interval setting
    watch <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, spa_pkg::OFS_IVAL, ivs[i]);
      repeat (3) wait_rise();
      check("interval", last_gap, gaps[i]);
    end
    $display("test interval done");
    complete_run();
  end
endmodule
